/* window_alert_pkg.sv */
// constants shared by the alert monitor and configuration register logic
`default_nettype none
package window_alert_pkg;

    // -------------------------------------------------------------------
    // register select codes (low three bits of the pointer byte)
    // -------------------------------------------------------------------
    localparam logic [2:0] PTR_RESULT = 3'h0;
    localparam logic [2:0] PTR_FLAGS = 3'h1;
    localparam logic [2:0] PTR_SETUP = 3'h2;
    localparam logic [2:0] PTR_LOW = 3'h3;
    localparam logic [2:0] PTR_HIGH = 3'h4;
    localparam logic [2:0] PTR_HYST = 3'h5;
    localparam int PTR_SEL_HI = 2;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int FLAG_OVER = 1;
    localparam int FLAG_UNDER = 0;
    localparam int SETUP_CYC_HI = 7;
    localparam int SETUP_CYC_LO = 5;
    localparam int SETUP_HOLD = 4;
    localparam int SETUP_FLAG_EN = 3;
    localparam int SETUP_PIN_EN = 2;
    localparam int SETUP_POL = 0;
    localparam int FIELD_HI = 11;
    localparam int FIELD_LO = 2;
    localparam int RESULT_ALERT_BIT = 15;
    localparam int LIMIT_W = 10;
    localparam int CYC_W = 3;

    // -------------------------------------------------------------------
    // writable-bit masks and reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] FLAGS_RW_MASK = 8'h03;
    localparam logic [7:0] SETUP_RW_MASK = 8'hFD;
    localparam logic [15:0] FIELD_RW_MASK = 16'h0FFC;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [15:0] LOW_RESET = 16'h0000;
    localparam logic [15:0] HIGH_RESET = 16'h0FFF;
    localparam logic [15:0] HYST_RESET = 16'h0000;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam logic [CYC_W-1:0] CYC_OFF = 3'h0;

    // -------------------------------------------------------------------
    // timing: single_conversion_time and the auto interval base
    // -------------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int SINGLE_CONVERSION_TIME_NS = 1000;
    localparam int CONV_CYCLES = (SINGLE_CONVERSION_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int INTERVAL_SHIFT = 4;
    localparam int TIMER_W = 24;

endpackage
`default_nettype wire

/* monitor_if.sv */
// carrier between the register bank and the limit monitor
`default_nettype none
interface monitor_if;
    logic [9:0] result;
    logic [9:0] high;
    logic [9:0] low;
    logic [9:0] hyst;
    logic conv_done;
    logic sticky;
    logic clr_over;
    logic clr_under;
    logic over;
    logic under;

    modport ctrl (
        output result, high, low, hyst, conv_done, sticky, clr_over, clr_under,
        input over, under
    );
    modport mon (
        input result, high, low, hyst, conv_done, sticky, clr_over, clr_under,
        output over, under
    );
endinterface
`default_nettype wire

/* limit_monitor.sv */
// threshold comparison and alert flag state
`default_nettype none
module limit_monitor
    import window_alert_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // bank side
    monitor_if.mon m
);
    logic [LIMIT_W:0] high_minus_hyst;
    logic [LIMIT_W:0] low_plus_hyst;
    logic hit_over;
    logic hit_under;
    logic rel_over;
    logic rel_under;

    // one extra bit keeps the difference and sum from wrapping
    assign high_minus_hyst = {1'b0, m.high} - {1'b0, m.hyst};
    assign low_plus_hyst = {1'b0, m.low} + {1'b0, m.hyst};

    assign hit_over = m.conv_done && (m.result > m.high);
    assign hit_under = m.conv_done && (m.result < m.low);
    // a hysteresis larger than the limit gives a negative bound: no release
    assign rel_over = m.conv_done && !m.sticky && !high_minus_hyst[LIMIT_W]
                      && ({1'b0, m.result} < high_minus_hyst);
    assign rel_under = m.conv_done && !m.sticky
                       && ({1'b0, m.result} > low_plus_hyst);

    // -------------------------------------------------------------------
    // flags: a new crossing wins over any clear in the same cycle
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            m.over <= 1'b0;
        end else if (hit_over) begin
            m.over <= 1'b1;
        end else if (m.clr_over || rel_over) begin
            m.over <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            m.under <= 1'b0;
        end else if (hit_under) begin
            m.under <= 1'b1;
        end else if (m.clr_under || rel_under) begin
            m.under <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* interval_timer.sv */
// pacing of automatic conversions
`default_nettype none
module interval_timer
    import window_alert_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic [CYC_W-1:0] cycle_code,
    // one-cycle start request
    output logic tick
);
    logic [TIMER_W-1:0] count_r;
    logic [TIMER_W-1:0] limit;
    logic [CYC_W-1:0] code_q_r;

    // code 1 is x32, each step doubles
    assign limit = TIMER_W'((CONV_CYC << (int'(cycle_code) + INTERVAL_SHIFT)) - 1);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            code_q_r <= CYC_OFF;
        end else begin
            code_q_r <= cycle_code;
        end
    end

    // restart the interval when the code changes; off clears the count
    always_ff @(posedge clk_sys) begin
        if (rst || cycle_code == CYC_OFF || cycle_code != code_q_r) begin
            count_r <= '0;
        end else if (count_r >= limit) begin
            count_r <= '0;
        end else begin
            count_r <= count_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= (cycle_code != CYC_OFF) && (cycle_code == code_q_r)
                    && (count_r >= limit);
        end
    end
endmodule
`default_nettype wire

/* window_alert_config_regs.sv */
// alert status, configuration and limit registers behind the address pointer
`default_nettype none
module window_alert_config_regs
    import window_alert_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pointer byte from the serial engine
    input wire logic ptr_wr,
    input wire logic [7:0] ptr_data,
    // register word access at the current pointer
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // converter
    input wire logic conv_done,
    input wire logic [9:0] conv_result,
    output logic conv_start,
    // alert pin
    output logic alert_o,
    output logic alert_oe
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    logic [7:0] pointer_r;
    logic [7:0] monitor_setup_r;
    logic [15:0] lower_threshold_r;
    logic [15:0] upper_threshold_r;
    logic [15:0] hysteresis_margin_r;
    logic [9:0] result_r;
    logic auto_tick;
    logic alert_active;
    logic [15:0] read_word;

    monitor_if mon_bus ();

    // -------------------------------------------------------------------
    // decoding
    // -------------------------------------------------------------------
    function automatic logic sel(input logic [7:0] ptr, input logic [2:0] code);
        sel = (ptr[PTR_SEL_HI:0] == code);
    endfunction

    function automatic logic [15:0] field_of(input logic [9:0] v);
        logic [15:0] w;
        w = '0;
        w[FIELD_HI:FIELD_LO] = v;
        field_of = w;
    endfunction

    // -------------------------------------------------------------------
    // address pointer
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pointer_r <= PTR_RESET;
        end else if (ptr_wr) begin
            pointer_r <= ptr_data;
        end
    end

    // -------------------------------------------------------------------
    // writable registers, reserved bits forced to zero
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            monitor_setup_r <= SETUP_RESET;
        end else if (reg_wr && sel(pointer_r, PTR_SETUP)) begin
            monitor_setup_r <= reg_wdata[7:0] & SETUP_RW_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lower_threshold_r <= LOW_RESET;
        end else if (reg_wr && sel(pointer_r, PTR_LOW)) begin
            lower_threshold_r <= reg_wdata & FIELD_RW_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            upper_threshold_r <= HIGH_RESET & FIELD_RW_MASK;
        end else if (reg_wr && sel(pointer_r, PTR_HIGH)) begin
            upper_threshold_r <= reg_wdata & FIELD_RW_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hysteresis_margin_r <= HYST_RESET;
        end else if (reg_wr && sel(pointer_r, PTR_HYST)) begin
            hysteresis_margin_r <= reg_wdata & FIELD_RW_MASK;
        end
    end

    // -------------------------------------------------------------------
    // latest conversion result
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            result_r <= RESULT_RESET;
        end else if (conv_done) begin
            result_r <= conv_result;
        end
    end

    // -------------------------------------------------------------------
    // limit monitor
    // -------------------------------------------------------------------
    assign mon_bus.result = conv_result;
    assign mon_bus.conv_done = conv_done;
    assign mon_bus.low = lower_threshold_r[FIELD_HI:FIELD_LO];
    assign mon_bus.high = upper_threshold_r[FIELD_HI:FIELD_LO];
    assign mon_bus.hyst = hysteresis_margin_r[FIELD_HI:FIELD_LO];
    assign mon_bus.sticky = monitor_setup_r[SETUP_HOLD];
    assign mon_bus.clr_over = reg_wr && sel(pointer_r, PTR_FLAGS)
                              && reg_wdata[FLAG_OVER];
    assign mon_bus.clr_under = reg_wr && sel(pointer_r, PTR_FLAGS)
                               && reg_wdata[FLAG_UNDER];

    limit_monitor u_monitor (
        .clk_sys(clk_sys),
        .rst(rst),
        .m(mon_bus.mon)
    );

    // -------------------------------------------------------------------
    // automatic conversion pacing
    // -------------------------------------------------------------------
    interval_timer #(
        .CONV_CYC(CONV_CYC)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .cycle_code(monitor_setup_r[SETUP_CYC_HI:SETUP_CYC_LO]),
        .tick(auto_tick)
    );

    // in normal mode reading the result word starts the next conversion
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= auto_tick
                          || (reg_rd && sel(pointer_r, PTR_RESULT)
                              && monitor_setup_r[SETUP_CYC_HI:SETUP_CYC_LO] == CYC_OFF);
        end
    end

    // -------------------------------------------------------------------
    // read path
    // -------------------------------------------------------------------
    assign alert_active = mon_bus.over || mon_bus.under;

    always_comb begin
        read_word = '0;
        unique case (pointer_r[PTR_SEL_HI:0])
            PTR_RESULT: begin
                read_word = field_of(result_r);
                read_word[RESULT_ALERT_BIT] = monitor_setup_r[SETUP_FLAG_EN]
                                              && alert_active;
            end
            PTR_FLAGS: begin
                read_word[FLAG_OVER] = mon_bus.over;
                read_word[FLAG_UNDER] = mon_bus.under;
            end
            PTR_SETUP: begin
                read_word[7:0] = monitor_setup_r;
            end
            PTR_LOW: begin
                read_word = lower_threshold_r;
            end
            PTR_HIGH: begin
                read_word = upper_threshold_r;
            end
            PTR_HYST: begin
                read_word = hysteresis_margin_r;
            end
            default: begin
                read_word = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= read_word;
        end
    end

    // -------------------------------------------------------------------
    // alert pin
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            alert_oe <= 1'b0;
        end else begin
            alert_oe <= monitor_setup_r[SETUP_PIN_EN];
        end
    end

    // inactive level is the inverse of the chosen polarity
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            alert_o <= 1'b1;
        end else begin
            alert_o <= (monitor_setup_r[SETUP_PIN_EN] && alert_active)
                       ? monitor_setup_r[SETUP_POL]
                       : !monitor_setup_r[SETUP_POL];
        end
    end
endmodule
`default_nettype wire

/* window_alert_config_regs_chk.sv */
// assertion checker for the alert register bank
`default_nettype none
module window_alert_config_regs_chk
    import window_alert_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register bus
    input wire logic ptr_wr,
    input wire logic [7:0] ptr_data,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // converter and pin
    input wire logic conv_done,
    input wire logic [9:0] conv_result,
    input wire logic conv_start,
    input wire logic alert_o,
    input wire logic alert_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ptr_r;
    logic [7:0] setup_r;
    logic [9:0] low_r;
    logic [9:0] high_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // -------------------------------------------------------------------
    // shadow of pointer, setup and limits
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ptr_r <= 3'h0;
            setup_r <= 8'h00;
            low_r <= 10'h000;
            high_r <= 10'h3FF;
        end else begin
            if (reg_wr && ptr_r == PTR_SETUP) setup_r <= reg_wdata[7:0] & SETUP_RW_MASK;
            if (reg_wr && ptr_r == PTR_LOW) low_r <= reg_wdata[11:2];
            if (reg_wr && ptr_r == PTR_HIGH) high_r <= reg_wdata[11:2];
            if (ptr_wr) ptr_r <= ptr_data[2:0];
        end
    end

    // -------------------------------------------------------------------
    // properties
    // -------------------------------------------------------------------
    chk_rd_start: assert property (
        reg_rd && ptr_r == PTR_RESULT && setup_r[7:5] == CYC_OFF |=> conv_start)
        else $error("read did not start a conversion");
    chk_oe_follow: assert property (
        alert_oe == $past(setup_r[SETUP_PIN_EN]))
        else $error("pin enable does not follow setup");
    chk_pol_idle: assert property (
        !$past(setup_r[SETUP_PIN_EN]) |-> alert_o == !$past(setup_r[SETUP_POL]))
        else $error("disabled pin not at inactive level");
    chk_rsv_bits: assert property (
        $past(ptr_r) != PTR_FLAGS && $past(ptr_r) != PTR_SETUP
        |-> reg_rdata[14:12] == 3'h0 && reg_rdata[1:0] == 2'h0)
        else $error("reserved read bits not zero");
    chk_setup_rsv: assert property (
        $past(ptr_r) == PTR_SETUP |-> reg_rdata[15:8] == 8'h00 && !reg_rdata[1])
        else $error("setup reserved bits not zero");
    chk_flags_rsv: assert property (
        $past(ptr_r) == PTR_FLAGS |-> reg_rdata[15:2] == 14'h0000)
        else $error("flag register upper bits not zero");
    chk_bit15_off: assert property (
        $past(ptr_r) == PTR_RESULT && !$past(setup_r[SETUP_FLAG_EN]) |-> !reg_rdata[15])
        else $error("result alert bit set while disabled");
    chk_w1c_clear: assert property (
        reg_wr && !ptr_wr && ptr_r == PTR_FLAGS && reg_wdata[1:0] == 2'h3 && !conv_done
        |=> ##1 reg_rdata[1:0] == 2'h0)
        else $error("write one did not clear flags");
    chk_over_set: assert property (
        conv_done && !reg_wr && conv_result > high_r && setup_r[SETUP_PIN_EN]
        |=> ##1 alert_oe && alert_o == $past(setup_r[SETUP_POL], 2))
        else $error("over range did not raise the pin");
    chk_under_set: assert property (
        conv_done && !reg_wr && conv_result < low_r && setup_r[SETUP_PIN_EN]
        |=> ##1 alert_oe && alert_o == $past(setup_r[SETUP_POL], 2))
        else $error("under range did not raise the pin");
endmodule

bind window_alert_config_regs window_alert_config_regs_chk #(.CONV_CYC(CONV_CYC)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .ptr_wr(ptr_wr), .ptr_data(ptr_data), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
    .conv_result(conv_result), .conv_start(conv_start), .alert_o(alert_o), .alert_oe(alert_oe)
);
`default_nettype wire

/* reg_ctrl_model.sv */
// serial controller model issuing pointer, write and read requests
`default_nettype none
module reg_ctrl_model
    import window_alert_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // register bus
    output logic ptr_wr,
    output logic [7:0] ptr_data,
    output logic reg_wr,
    output logic [15:0] reg_wdata,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ptr_wr = 1'b0;
        ptr_data = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd = 1'b0;
    end

    // released data lines show the inverse of the last value
    task automatic set_ptr(input logic [2:0] p);
        @(negedge clk_sys);
        ptr_wr = 1'b1;
        ptr_data = {5'h00, p};
        @(negedge clk_sys);
        ptr_wr = 1'b0;
        ptr_data = ~ptr_data;
    endtask

    task automatic write_reg(input logic [2:0] p, input logic [15:0] d, input logic raw);
        logic [15:0] m;
        case (p)
            PTR_FLAGS: m = d & {8'h00, FLAGS_RW_MASK};
            PTR_SETUP: m = d & {8'h00, SETUP_RW_MASK};
            default: m = d & FIELD_RW_MASK;
        endcase
        set_ptr(p);
        reg_wr = 1'b1;
        reg_wdata = raw ? d : m;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata;
    endtask

    task automatic read_reg(input logic [2:0] p, output logic [15:0] d);
        set_ptr(p);
        @(negedge clk_sys);
        d = reg_rdata;
    endtask

    task automatic pulse_rd();
        @(negedge clk_sys);
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
    endtask
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the alert register bank
`default_nettype none
module testbench
    import window_alert_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CC = 1;
    logic clk_sys;
    logic rst;
    logic conv_done;
    logic [9:0] conv_result;
    wire logic ptr_wr, reg_wr, reg_rd, conv_start, alert_o, alert_oe;
    wire logic [7:0] ptr_data;
    wire logic [15:0] reg_wdata, reg_rdata;
    int m_flags, m_setup, m_low, m_high, m_hyst, m_res;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;

    window_alert_config_regs #(.CONV_CYC(CC)) u_window_alert_config_regs (
        .clk_sys(clk_sys), .rst(rst), .ptr_wr(ptr_wr), .ptr_data(ptr_data), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
        .conv_result(conv_result), .conv_start(conv_start), .alert_o(alert_o), .alert_oe(alert_oe)
    );
    reg_ctrl_model u_reg_ctrl_model (
        .clk_sys(clk_sys), .ptr_wr(ptr_wr), .ptr_data(ptr_data), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // -------------------------------------------------------------------
    // checking and model
    // -------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
        n_tests++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    function automatic logic [15:0] exp_rd(input int p);
        case (p)
            0: return {m_setup[3] && m_flags != 0, 3'h0, m_res[9:0], 2'h0};
            1: return 16'(m_flags);
            2: return 16'(m_setup);
            3: return 16'(m_low << 2);
            4: return 16'(m_high << 2);
            5: return 16'(m_hyst << 2);
            default: return 16'h0000;
        endcase
    endfunction

    task automatic rd(input int p, input string what);
        logic [15:0] d;
        u_reg_ctrl_model.read_reg(3'(p), d);
        check(d, exp_rd(p), what);
    endtask

    task automatic wr(input int p, input logic [15:0] d, input logic raw);
        u_reg_ctrl_model.write_reg(3'(p), d, raw);
        case (p)
            1: m_flags = m_flags & ~int'(d[1:0]);
            2: m_setup = d[7:0] & 8'hFD;
            3: m_low = d[11:2];
            4: m_high = d[11:2];
            5: m_hyst = d[11:2];
            default: ;
        endcase
    endtask

    task automatic conv(input int r);
        logic pin_want;
        @(negedge clk_sys);
        conv_done = 1'b1;
        conv_result = 10'(r);
        if (r > m_high) m_flags |= 2;
        else if (!m_setup[4] && m_hyst <= m_high && r < m_high - m_hyst)
            m_flags &= 1;
        if (r < m_low) m_flags |= 1;
        else if (!m_setup[4] && r > m_low + m_hyst) m_flags &= 2;
        m_res = r;
        @(negedge clk_sys);
        conv_done = 1'b0;
        conv_result = ~conv_result;
        @(negedge clk_sys);
        check(16'(alert_oe), 16'(m_setup[2]), "pin enable");
        pin_want = m_setup[2] && m_flags != 0 ? m_setup[0] : !m_setup[0];
        check(16'(alert_o), 16'(pin_want), "pin");
    endtask

    task automatic wait_start(output int n);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (conv_start !== 1'b1 && n < 5000);
    endtask

    task automatic complete_run();
        $display("TB: %0d checks, %0d wrong", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            $display("wrong value at %0t: run timed out", $time);
            complete_run();
        end
    end

    // -------------------------------------------------------------------
    // tests
    // -------------------------------------------------------------------
    initial begin
        int k;
        int n;
        rst = 1'b1;
        conv_done = 1'b0;
        conv_result = 10'h000;
        m_flags = 0;
        m_setup = 0;
        m_low = 0;
        m_high = 1023;
        m_hyst = 0;
        m_res = 0;
        n = $urandom(32'hB675);
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        for (int p = 0; p < 8; p++) rd(p, "reset");
        $display("TB: reset values done");
        for (int i = 0; i < 16; i++) begin
            k = $urandom_range(7, 0);
            wr(k, 16'($urandom), i[0]);
            rd(k, "register write");
        end
        $display("TB: register access done");
        wr(3, 16'($urandom_range(400, 100)) << 2, 1'b0);
        wr(4, 16'($urandom_range(900, 600)) << 2, 1'b0);
        wr(5, 16'($urandom_range(80, 0)) << 2, 1'b0);
        for (int i = 0; i < 48; i++) begin
            if (i % 12 == 0) wr(2, 16'({3'($urandom), 1'((i / 12) % 2), 4'($urandom)}), 1'b0);
            conv($urandom_range(1023, 0));
            rd(1, "alert flags");
            rd(0, "result word");
            if ($urandom_range(3, 0) == 0) wr(1, 16'($urandom_range(3, 0)), 1'b0);
        end
        $display("TB: limit monitor done");
        wr(2, 16'h0000, 1'b0);
        u_reg_ctrl_model.set_ptr(PTR_RESULT);
        n = 0;
        repeat (100) begin
            @(negedge clk_sys);
            n += (conv_start !== 1'b0);
        end
        check(16'(n), 16'h0000, "idle starts");
        u_reg_ctrl_model.pulse_rd();
        check(16'(conv_start), 16'h0001, "read start");
        @(negedge clk_sys);
        check(16'(conv_start), 16'h0000, "start pulse");
        for (k = 1; k < 8; k++) begin
            wr(2, 16'(k << 5), 1'b0);
            wait_start(n);
            wait_start(n);
            check(16'(n), 16'(CC << (k + 4)), "auto interval");
        end
        $display("TB: conversion pacing done");
        complete_run();
    end
endmodule
`default_nettype wire
